// *** rtl/sraa_host.sv ***
`timescale 1ns/1ps
// Summary of operation
// [RULE1] drive three active-low strobes: select, output, write
// [RULE2] cycle starts at select fall, address held
// [RULE3] wait line is open drain, only read here
// [RULE4] wait low only on select during refresh
// [RULE5] wait goes low within 50 ns
// [RULE6] wait held low until refresh and access done
// [RULE7] device orders refresh before delayed access
// [RULE8] read data valid 60 ns after wait release
// [RULE9] write strobe stays high during reads
// [RULE10] data floats 10 to 60 ns after output off
// [RULE11] pulse mode: strobe 0 to 90 ns after select
// [RULE12] long mode: strobe within 10 us, select held
// [RULE13] no-op select low no longer than 10000 ns
// [RULE14] select high 200 ns after a no-op
// [RULE15] 250 ns from wait release to select
// [RULE16] no-op cycle: select without either strobe
// [RULE17] write data taken at write strobe fall
// [RULE18] device refresh timer runs every 24 us
// [RULE19] wait ignores refreshes during extended strobes
// [RULE20] refresh busy postpones access, wait shows it
module sraa_host
  import sraa_pkg::*;
#(
  parameter int AW = sraa_pkg::ADDR_W,
  parameter int DW = sraa_pkg::DATA_W
) (
  input  wire logic          sys_clk,      // user clock
  input  wire logic          rst_n,        // sync reset, active low
  input  wire logic          link_clk,     // pin-side clock
  input  wire logic          usr_valid,    // request offered
  output logic               usr_ready,    // request accepted
  input  wire sraa_pkg::sraa_cmd_t usr_cmd, // read, write or no-op
  input  wire logic [AW-1:0] usr_addr,     // word address
  input  wire logic [DW-1:0] usr_wdata,    // write data
  input  wire logic          usr_long,     // long select mode
  output logic               rsp_valid,    // one-cycle completion
  output logic      [DW-1:0] rsp_rdata,    // read data
  output logic               rsp_waited,   // cycle was delayed
  output logic               mem_ce_n,     // chip select, active low
  output logic               mem_oe_n,     // output enable, active low
  output logic               mem_we_n,     // write strobe, active low
  output logic      [AW-1:0] mem_addr,     // address pins
  output logic      [DW-1:0] mem_dq_o,     // data pins, out value
  output logic               mem_dq_oe,    // data pins, drive enable
  input  wire logic [DW-1:0] mem_dq_i,     // data pins, in value
  input  wire logic          mem_rdy       // wait line, wired level
);

  // ---------------- user clock domain ----------------
  logic            busy_r;      // request outstanding
  logic            req_tgl_r;   // request event toggle
  sraa_cmd_t       cmd_r;       // held command
  logic [AW-1:0]   addr_r;      // held address
  logic [DW-1:0]   wdata_r;     // held write data
  logic            long_r;      // held mode
  logic            done_s;      // synced completion toggle
  logic            done_d_r;    // previous synced toggle
  logic            rsp_valid_r; // completion pulse
  logic [DW-1:0]   rsp_rdata_r; // returned data
  logic            rsp_wait_r;  // returned wait flag
  logic            link_rst_n;  // reset seen in link domain

  // ---------------- link clock domain ----------------
  sraa_state_t     st_r;        // sequencer state
  sraa_state_t     st_nxt;      // next state
  logic [CNT_W-1:0] tmr_r;      // cycles since select fall
  logic [CNT_W-1:0] wt_r;       // cycles since wait release
  logic [CNT_W-1:0] gap_r;      // select high time still owed
  logic            req_s;       // synced request toggle
  logic            req_d_r;     // previous synced toggle
  logic            pend_r;      // request waiting to start
  logic            waited_r;    // wait seen this cycle
  sraa_cmd_t       lcmd_r;      // command in progress
  logic            llong_r;     // mode in progress
  logic            ce_n_r;      // select drive
  logic            oe_n_r;      // output enable drive
  logic            we_n_r;      // write strobe drive
  logic            dq_oe_r;     // data drive enable
  logic [AW-1:0]   laddr_r;     // address drive
  logic [DW-1:0]   ldq_r;       // data drive
  logic [DW-1:0]   lrdata_r;    // captured read data
  logic            done_tgl_r;  // completion event toggle
  logic [DW-1:0]   dq_s;        // synced data pins
  logic            rdy_s;       // synced wait line

  // ---------------- decode wires ----------------
  logic            accept;      // user request taken
  logic            done_edge;   // completion arrived
  logic            req_edge;    // request arrived
  logic            start;       // launch a memory cycle
  logic            finish;      // end a memory cycle
  logic            rdy_low;     // wait line pulled low
  logic            is_read;     // cycle is a read
  logic            is_write;    // cycle is a write
  logic            is_noop;     // cycle is a no-op
  logic [CNT_W-1:0] end_cyc;    // strobe end count
  logic [CNT_W-1:0] gap_load;   // select high time to owe
  logic            ce_release;  // pulse mode select end
  logic            tmr_sat;     // timer at its top

  // user handshake decode
  assign usr_ready = ~busy_r;
  assign accept    = usr_valid & ~busy_r;
  assign done_edge = done_s ^ done_d_r;
  assign rsp_valid  = rsp_valid_r;
  assign rsp_rdata  = rsp_rdata_r;
  assign rsp_waited = rsp_wait_r;

  // request capture and busy tracking
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      busy_r    <= 1'b0;
      req_tgl_r <= 1'b0;
    end
    else if (accept)
    begin
      busy_r    <= 1'b1;
      req_tgl_r <= ~req_tgl_r;
    end
    else if (done_edge)
    begin
      busy_r    <= 1'b0;
    end
  end

  // held request fields, stable while busy
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cmd_r   <= SRAA_CMD_NOOP;
      addr_r  <= '0;
      wdata_r <= '0;
      long_r  <= 1'b0;
    end
    else if (accept)
    begin
      cmd_r   <= usr_cmd;
      addr_r  <= usr_addr;
      wdata_r <= usr_wdata;
      long_r  <= usr_long;
    end
  end

  // completion pulse and returned fields
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      done_d_r    <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= '0;
      rsp_wait_r  <= 1'b0;
    end
    else
    begin
      done_d_r    <= done_s;
      rsp_valid_r <= done_edge;
      if (done_edge)
      begin
        rsp_rdata_r <= lrdata_r;   // stable since toggle
        rsp_wait_r  <= waited_r;
      end
    end
  end

  // crossings into each domain
  sraa_sync #(.WIDTH(1)) u_done_sync (
    .clk (sys_clk),
    .d   (done_tgl_r),
    .q   (done_s)
  );

  sraa_sync #(.WIDTH(1)) u_rst_sync (
    .clk (link_clk),
    .d   (rst_n),
    .q   (link_rst_n)
  );

  sraa_sync #(.WIDTH(1)) u_req_sync (
    .clk (link_clk),
    .d   (req_tgl_r),
    .q   (req_s)
  );

  sraa_sync #(.WIDTH(1)) u_rdy_sync (
    .clk (link_clk),
    .d   (mem_rdy),
    .q   (rdy_s)
  );

  sraa_sync #(.WIDTH(DW)) u_dq_sync (
    .clk (link_clk),
    .d   (mem_dq_i),
    .q   (dq_s)
  );

  // link-side decode
  assign req_edge = req_s ^ req_d_r;
  assign rdy_low  = ~rdy_s;                       // RULE3
  assign is_read  = (lcmd_r == SRAA_CMD_READ);
  assign is_write = (lcmd_r == SRAA_CMD_WRITE);
  assign is_noop  = (lcmd_r == SRAA_CMD_NOOP);
  assign tmr_sat  = &tmr_r;
  // strobe end: access time, or wait window for a no-op
  assign end_cyc  = is_noop ? RDY_CHECK_CYC : ACCESS_END_CYC; // RULE16
  // spacing owed before the next select fall
  assign gap_load = waited_r ? RDY_GAP_CYC :            // RULE15
                    is_noop  ? NOOP_HIGH_CYC :          // RULE14
                               FLOAT_CYC;               // RULE10
  // next select only after gap and full cycle time
  assign start    = (st_r == L_IDLE) & pend_r & (gap_r == '0) &
                    (tmr_r >= CYCLE_CYC);
  assign finish   = ((st_r == L_STROBE) & ~rdy_low & (tmr_r >= end_cyc)) |
                    ((st_r == L_POST) & (wt_r >= POST_CYC));  // RULE8
  // pulse mode drops select early; long mode holds it
  assign ce_release = ~llong_r & (tmr_r >= CE_PULSE_CYC); // RULE11

  // sequencer next state
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      L_IDLE:
        if (start)
          st_nxt = L_SEL;
      L_SEL:
        if (tmr_r >= SEL_STROBE_CYC - 12'h001)
          st_nxt = L_STROBE;
      L_STROBE:
        if (rdy_low)
          st_nxt = L_WAIT;                  // RULE20
        else if (finish)
          st_nxt = L_IDLE;
      L_WAIT:
        if (!rdy_low)
          st_nxt = L_POST;                  // RULE6
      L_POST:
        if (finish)
          st_nxt = L_IDLE;
      default:
        st_nxt = L_IDLE;
    endcase
  end

  // state, request edge and pending flag
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      st_r    <= L_IDLE;
      req_d_r <= 1'b0;
      pend_r  <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      req_d_r <= req_s;
      if (req_edge)
        pend_r <= 1'b1;                     // held fields now stable
      else if (start)
        pend_r <= 1'b0;
    end
  end

  // timers: since select fall, since wait release, gap owed
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      tmr_r <= CYCLE_CYC;
      wt_r  <= '0;
      gap_r <= '0;
    end
    else
    begin
      tmr_r <= start ? '0 : (tmr_sat ? tmr_r : tmr_r + 12'h001);
      wt_r  <= (st_r == L_POST) ? wt_r + 12'h001 : '0;
      gap_r <= finish ? gap_load :
               (gap_r != '0) ? gap_r - 12'h001 : gap_r;
    end
  end

  // latch the command at select fall; capture address once
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      lcmd_r  <= SRAA_CMD_NOOP;
      llong_r <= 1'b0;
      laddr_r <= '0;
      ldq_r   <= '0;
    end
    else if (start)
    begin
      lcmd_r  <= cmd_r;
      llong_r <= long_r;                    // RULE12
      laddr_r <= addr_r;                    // RULE2
      ldq_r   <= wdata_r;                   // RULE17
    end
  end

  // chip select drive
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
      ce_n_r <= PIN_IDLE_LVL;
    else if (start)
      ce_n_r <= 1'b0;                       // RULE1
    else if (finish | ce_release)
      ce_n_r <= PIN_IDLE_LVL;               // RULE13
  end

  // output enable and write strobe drive
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      oe_n_r <= PIN_IDLE_LVL;
      we_n_r <= PIN_IDLE_LVL;
    end
    else if (finish)
    begin
      oe_n_r <= PIN_IDLE_LVL;
      we_n_r <= PIN_IDLE_LVL;
    end
    else if (st_r == L_SEL && st_nxt == L_STROBE)
    begin
      oe_n_r <= ~is_read;                   // RULE9
      we_n_r <= ~is_write;                  // RULE17
    end
  end

  // write data drive, set up before the write strobe falls
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
      dq_oe_r <= 1'b0;
    else if (start)
      dq_oe_r <= (cmd_r == SRAA_CMD_WRITE); // RULE10
    else if (finish)
      dq_oe_r <= 1'b0;
  end

  // wait flag, read capture and completion toggle
  always_ff @(posedge link_clk)
  begin
    if (!link_rst_n)
    begin
      waited_r   <= 1'b0;
      lrdata_r   <= '0;
      done_tgl_r <= 1'b0;
    end
    else
    begin
      if (start)
        waited_r <= 1'b0;
      else if (st_r == L_STROBE && rdy_low)
        waited_r <= 1'b1;                   // RULE5
      if (finish)
      begin
        if (is_read)
          lrdata_r <= dq_s;                 // RULE8
        done_tgl_r <= ~done_tgl_r;
      end
    end
  end

  // pin outputs, all from flops
  assign mem_ce_n  = ce_n_r;
  assign mem_oe_n  = oe_n_r;
  assign mem_we_n  = we_n_r;
  assign mem_addr  = laddr_r;
  assign mem_dq_o  = ldq_r;
  assign mem_dq_oe = dq_oe_r;

endmodule

// *** include/sraa_pkg.sv ***
package sraa_pkg;

  // command codes passed from the user side to the pin side
  typedef enum logic [1:0]
  {
    SRAA_CMD_READ  = 2'h0,
    SRAA_CMD_WRITE = 2'h1,
    SRAA_CMD_NOOP  = 2'h2
  } sraa_cmd_t;

  // pin-side sequencer states
  typedef enum logic [2:0]
  {
    L_IDLE,
    L_SEL,
    L_STROBE,
    L_WAIT,
    L_POST
  } sraa_state_t;

  // bus widths of the memory, and timer width
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 12;

  // link clock period and synchroniser depth
  localparam int LINK_PERIOD_NS = 6;
  localparam int SYNC_STAGES    = 2;

  // pin timing figures in ns
  localparam int T_CE_PULSE_NS     = 40;    // least chip select low time
  localparam int T_SEL_STROBE_NS   = 90;    // pulse mode strobe window
  localparam int T_LONG_STROBE_NS  = 10000; // long mode strobe window
  localparam int T_NOOP_CE_MAX_NS  = 10000; // longest no-op select low
  localparam int T_NOOP_HIGH_NS    = 200;   // select high after no-op
  localparam int T_CYCLE_NS        = 425;   // select_cycle_time
  localparam int T_ACCESS_NS       = 250;   // select to data, strobe hold
  localparam int T_RDY_LOW_NS      = 50;    // select fall to wait low
  localparam int T_RDY_TO_DATA_NS  = 60;    // wait_release_to_data
  localparam int T_RDY_TO_CE_NS    = 250;   // wait high to next select
  localparam int T_FLOAT_NS        = 60;    // output_off_to_float

  // derived cycle counts (least times round up)
  localparam logic [CNT_W-1:0] SEL_STROBE_CYC = 12'h001;
  localparam logic [CNT_W-1:0] SEL_STROBE_MAX_CYC =
    CNT_W'(T_SEL_STROBE_NS / LINK_PERIOD_NS);
  localparam logic [CNT_W-1:0] NOOP_CE_MAX_CYC =
    CNT_W'(T_NOOP_CE_MAX_NS / LINK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CE_PULSE_CYC =
    CNT_W'((T_CE_PULSE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [CNT_W-1:0] NOOP_HIGH_CYC =
    CNT_W'((T_NOOP_HIGH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CYCLE_CYC =
    CNT_W'((T_CYCLE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACCESS_END_CYC =
    CNT_W'((T_ACCESS_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS
           + SYNC_STAGES);
  localparam logic [CNT_W-1:0] RDY_CHECK_CYC =
    CNT_W'((T_RDY_LOW_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS
           + SYNC_STAGES);
  localparam logic [CNT_W-1:0] POST_CYC =
    CNT_W'((T_RDY_TO_DATA_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS
           + SYNC_STAGES);
  localparam logic [CNT_W-1:0] RDY_GAP_CYC =
    CNT_W'((T_RDY_TO_CE_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [CNT_W-1:0] FLOAT_CYC =
    CNT_W'((T_FLOAT_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);

  // reset values of pin drives
  localparam logic PIN_IDLE_LVL = 1'b1;

endpackage

// *** rtl/sraa_sync.sv ***
`timescale 1ns/1ps
// two-flop synchroniser, first stage feeds only the second
module sraa_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,   // destination clock
  input  wire logic [WIDTH-1:0] d,     // asynchronous input
  output logic      [WIDTH-1:0] q      // synchronised output
);

  logic [WIDTH-1:0] meta_r;            // first stage

  // two stages, no reset so reset itself can pass through
  always_ff @(posedge clk)
  begin
    meta_r <= d;
    q      <= meta_r;
  end

endmodule

// *** bench/sraa_host_assertions.sv ***
`timescale 1ns/1ps
// pin checks of the memory host, link clock domain
module sraa_host_assertions
  import sraa_pkg::*;
(
  input wire logic              link_clk,  // pin clock
  input wire logic              rst_n,     // reset, active low
  input wire logic              mem_ce_n,  // select
  input wire logic              mem_oe_n,  // output enable
  input wire logic              mem_we_n,  // write strobe
  input wire logic [ADDR_W-1:0] mem_addr,  // address pins
  input wire logic [DATA_W-1:0] mem_dq_o,  // write data
  input wire logic              mem_dq_oe, // host drives data
  input wire logic              mem_rdy    // wait level
);
  logic       ce_q_r; // select one cycle back
  logic       acc_r;  // strobe seen in this cycle
  logic [5:0] hi_r;   // select high run
  logic [5:0] rh_r;   // wait high run
  logic [CNT_W-1:0] lo_r; // select low run, saturating
  wire        ce_fall = ce_q_r & ~mem_ce_n; // select fall
  // saturating run counters
  always_ff @(posedge link_clk)
  begin
    if (!rst_n)
    begin
      ce_q_r <= 1'b1;
      acc_r  <= 1'b1;
      hi_r   <= 6'h3f;
      rh_r   <= 6'h3f;
      lo_r   <= '0;
    end
    else
    begin
      ce_q_r <= mem_ce_n;
      acc_r  <= ce_fall ? 1'b0 : acc_r | ~mem_oe_n | ~mem_we_n;
      hi_r   <= mem_ce_n ? hi_r + {5'h00, hi_r != 6'h3f} : 6'h00;
      rh_r   <= mem_rdy ? rh_r + {5'h00, rh_r != 6'h3f} : 6'h00;
      // select low cycles so far, counted instead of a long delay
      lo_r   <= mem_ce_n ? '0 : lo_r + {{(CNT_W-1){1'b0}}, ~&lo_r};
    end
  end
  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (!rst_n);
  property p_addr_hold; !$fell(mem_ce_n) |-> $stable(mem_addr); endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved off select fall");
  property p_read_no_we; !mem_oe_n |-> mem_we_n; endproperty
  a_read_no_we: assert property (p_read_no_we)
    else $error("write strobe low in read");
  property p_read_no_drv; !mem_oe_n |-> !mem_dq_oe; endproperty
  a_read_no_drv: assert property (p_read_no_drv)
    else $error("host drives data in read");
  property p_strobe_lag;
    $fell(mem_oe_n) || $fell(mem_we_n) |->
      $past(mem_ce_n, 2) && !$past(mem_ce_n);
  endproperty
  a_strobe_lag: assert property (p_strobe_lag)
    else $error("strobe not one cycle after select");
  property p_wdata_hold; !mem_we_n |-> mem_dq_oe && $stable(mem_dq_o);
  endproperty
  a_wdata_hold: assert property (p_wdata_hold)
    else $error("write data moved under strobe");
  property p_noop_len;
    !mem_ce_n && !acc_r && mem_oe_n && mem_we_n |->
      lo_r < NOOP_CE_MAX_CYC;
  endproperty
  a_noop_len: assert property (p_noop_len)
    else $error("no-op select too long");
  property p_noop_gap; ce_fall && !acc_r |-> hi_r >= 6'h22; endproperty
  a_noop_gap: assert property (p_noop_gap)
    else $error("select high too short after no-op");
  property p_rdy_gap; ce_fall |-> rh_r >= 6'h2a; endproperty
  a_rdy_gap: assert property (p_rdy_gap)
    else $error("select too soon after wait release");
  property p_wait_hold; !mem_rdy && !mem_oe_n |=> !mem_oe_n; endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("read strobe left during wait");
endmodule
bind sraa_host sraa_host_assertions sraa_host_assertions_inst (
  .link_clk(link_clk), .rst_n(rst_n), .mem_ce_n(mem_ce_n),
  .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n), .mem_addr(mem_addr),
  .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe), .mem_rdy(mem_rdy)
);

// *** bench/sraa_mem_model.sv ***
`timescale 1ns/1ps
// self-refreshing memory seen at its pins
module sraa_mem_model
  import sraa_pkg::*;
#(
  parameter int REF_PERIOD_NS = 24000, // refresh timer
  parameter int REF_NS        = 600    // refresh busy time
) (
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic [ADDR_W-1:0] addr,     // address
  input  wire logic [DATA_W-1:0] dq_in,    // host data
  input  wire logic              dq_in_en, // host drives
  input  wire logic              ref_kick, // force refresh
  output logic      [DATA_W-1:0] dq_out,   // data to host
  output logic                   rdy_pull
);
  logic [DATA_W-1:0] mem [2**ADDR_W]; // array
  logic [ADDR_W-1:0] a_r;             // latched address
  logic [DATA_W-1:0] last = 8'h00;    // last bus value
  logic              busy = 1'b0;     // refresh running
  logic              pend = 1'b0;     // access delayed
  logic              drv = 1'b0;      // driving data
  logic              waited = 1'b0;   // select met refresh
  initial rdy_pull = 1'b0;
  // released bus shows the inverse of its last value
  assign dq_out = drv ? mem[a_r] : ~last;
  // one refresh
  task automatic do_ref();
    busy = 1'b1;
    #(REF_NS);
    busy = 1'b0;
  endtask
  // free-running timer
  always
  begin
    #(REF_PERIOD_NS);
    do_ref();
  end
  always @(posedge ref_kick) do_ref();
  // select fall latches address, refresh delays access
  always @(negedge ce_n)
  begin
    // host moves address on the select edge; sample inside hold time
    #1 a_r = addr;
    waited = busy;
    if (busy)
    begin
      pend = 1'b1;
      #20 rdy_pull = 1'b1;
      wait (!busy);
      #150 rdy_pull = 1'b0;
      #40 pend = 1'b0;
    end
  end
  // only a write strobe fall touches the array
  always @(negedge we_n)
    mem[a_r] = dq_in_en ? dq_in : 8'hxx;
  // drive follows enable, floats late
  always @(oe_n or pend)
  begin
    if (!oe_n && !pend)
      drv = 1'b1;
    else if (oe_n)
      drv <= #30 1'b0;
  end
  always @(posedge drv) last = mem[a_r];
endmodule

// *** bench/sraa_host_tb.sv ***
`timescale 1ns/1ps
// host bench against the behavioural memory
module sraa_host_tb;
  import sraa_pkg::*;
  logic sys_clk, link_clk, rst_n, usr_valid, usr_ready, usr_long; // user
  sraa_cmd_t usr_cmd;                                 // command
  logic [ADDR_W-1:0] usr_addr, mem_addr;              // addresses
  logic [DATA_W-1:0] usr_wdata, rsp_rdata, mem_dq_o, mem_dq_i; // data
  logic rsp_valid, rsp_waited, mem_ce_n, mem_oe_n, mem_we_n; // flags
  logic mem_dq_oe, rdy_pull, ref_kick;                // pin side
  wire  mem_rdy = !rdy_pull;                          // pull-up
  wire  mdl_waited = sraa_mem_model_inst.waited;      // model view
  int   mismatches;
  int   samples_checked;
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #1.3;
    forever #3 link_clk = ~link_clk;
  end
  sraa_host sraa_host_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
    .usr_valid(usr_valid), .usr_ready(usr_ready), .usr_cmd(usr_cmd),
    .usr_addr(usr_addr), .usr_wdata(usr_wdata), .usr_long(usr_long),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_waited(rsp_waited), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n), .mem_addr(mem_addr), .mem_dq_o(mem_dq_o),
    .mem_dq_oe(mem_dq_oe), .mem_dq_i(mem_dq_i), .mem_rdy(mem_rdy)
  );
  sraa_mem_model sraa_mem_model_inst (
    .ce_n(mem_ce_n), .oe_n(mem_oe_n), .we_n(mem_we_n), .addr(mem_addr),
    .dq_in(mem_dq_o), .dq_in_en(mem_dq_oe), .ref_kick(ref_kick),
    .dq_out(mem_dq_i), .rdy_pull(rdy_pull)
  );
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("mismatches %0d checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk_wait();
    chk("waited", 8'(rsp_waited), 8'(mdl_waited));
  endtask
  // one request, bounded wait for completion
  task automatic req(sraa_cmd_t c, logic [12:0] a, logic [7:0] d, logic lg);
    int n;
    n = 0;
    usr_cmd = c;
    usr_addr = a;
    usr_wdata = d;
    usr_long = lg;
    usr_valid = 1'b1;
    @(negedge sys_clk);
    usr_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 3000)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 3000)
    begin
      chk("timeout", 8'h01, 8'h00);
      wrap_up();
    end
  endtask
  // reset and idle pins
  task automatic reset_chk();
    rst_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    chk("idle", {2'h0, usr_ready, rsp_valid, mem_ce_n, mem_oe_n,
                 mem_we_n, mem_dq_oe}, 8'h2e);
    rst_n = 1'b1;
    @(negedge sys_clk);
  endtask
  // writes then reads back, both select modes
  task automatic t_rw();
    for (int i = 0; i < 4; i++)
      req(SRAA_CMD_WRITE, 13'h1fff - 13'(i * 2730), 8'(i * 37 + 5), i[0]);
    for (int i = 0; i < 4; i++)
    begin
      req(SRAA_CMD_READ, 13'h1fff - 13'(i * 2730), 8'h00, !i[0]);
      chk("read", rsp_rdata, 8'(i * 37 + 5));
      chk_wait();
    end
  endtask
  // no-op cycles leave the array alone
  task automatic t_noop();
    for (int lg = 0; lg < 2; lg++)
    begin
      req(SRAA_CMD_NOOP, 13'h1fff, 8'hee, lg[0]);
      chk("noop", sraa_mem_model_inst.mem[13'h1fff], 8'h05);
      chk_wait();
    end
    req(SRAA_CMD_READ, 13'h1fff, 8'h00, 1'b0);
    chk("after noop", rsp_rdata, 8'h05);
  endtask
  // every command meets a refresh at select fall
  task automatic t_collide();
    sraa_cmd_t c [3] = '{SRAA_CMD_WRITE, SRAA_CMD_READ, SRAA_CMD_NOOP};
    for (int i = 0; i < 3; i++)
    begin
      @(negedge sys_clk);
      ref_kick = 1'b1;
      req(c[i], 13'h0000, 8'h5a, i[0]);
      ref_kick = 1'b0;
      chk("waited", 8'(rsp_waited), 8'h01);
      if (i == 1)
        chk("late data", rsp_rdata, 8'h5a);
    end
  endtask
  // refresh under a held strobe stays hidden
  task automatic t_ext();
    int n;
    n = 0;
    fork
      req(SRAA_CMD_READ, 13'h1555, 8'h00, 1'b1);
      begin
        while (mem_oe_n !== 1'b0 && n < 200)
        begin
          @(negedge sys_clk);
          n++;
        end
        ref_kick = 1'b1;
      end
    join
    ref_kick = 1'b0;
    if (n >= 200)
    begin
      chk("ext timeout", 8'h01, 8'h00);
      wrap_up();
    end
    chk("ext waited", 8'(rsp_waited), 8'h00);
    chk("ext data", rsp_rdata, 8'h2a);
  endtask
  // main sequence
  initial
  begin
    mismatches = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    usr_valid = 1'b0;
    usr_cmd = SRAA_CMD_READ;
    usr_addr = 13'h0000;
    usr_wdata = 8'h00;
    usr_long = 1'b0;
    ref_kick = 1'b0;
    @(negedge sys_clk);
    reset_chk();
    t_rw();
    t_noop();
    t_collide();
    t_ext();
    reset_chk();
    req(SRAA_CMD_READ, 13'h0000, 8'h00, 1'b0);
    chk("after reset", rsp_rdata, 8'h5a);
    chk_wait();
    wrap_up();
  end
endmodule
